// ---- rtl/quad_dac_serial_chain_port.sv ----
// Serial host port of a quad 8-bit converter with daisy-chain output.
// Assumes the host drives sclk, cs_n and din, and that words reach the
// command logic on clk through a FIFO after chip select rises.
`timescale 1ns/1ps
`include "dac_map.svh"

module quad_dac_serial_chain_port import dac_pkg::*; #(
  parameter int DEPTH = `FIFO_DEPTH
) (
  // System clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Serial link from the host
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  // Flow control
  input wire logic apply_hold,
  output logic word_ready,
  // Converter state
  output code_t [`NUM_CH-1:0] output_code_value,
  output logic shutdown,
  output logic upo,
  output logic dout_rising_mode
);

  function automatic logic updates_all(input op_t op);
    updates_all = (op[`CTL_MSB:`CTL_LSB] == `CTL_LOAD_UPD) ||
                  (op == `OP_UPDATE) || (op == `OP_MODE_RISE) ||
                  (op == `OP_MODE_FALL);
  endfunction : updates_all

  function automatic logic is_load(input op_t op);
    is_load = (op[`CTL_MSB:`CTL_LSB] == `CTL_LOAD) ||
              (op[`CTL_MSB:`CTL_LSB] == `CTL_LOAD_UPD);
  endfunction : is_load

  function automatic logic is_nop(input op_t op);
    is_nop = (op == `OP_NOP);
  endfunction : is_nop

  // ---------------- Link domain on the serial clock ----------------
  word_t sreg_q, sreg_d;
  logic out_bit_q, out_bit_d;
  logic fall_q, fall_d;
  logic [`SYNC_STAGES-1:0] mode_sync_q, mode_sync_d;
  logic mode_link_q, mode_link_d;
  logic [`SHIFT_CNT_W-1:0] shift_cnt_q, shift_cnt_d;
  logic dout_d;
  logic mode_q;

  always_comb begin
    sreg_d = sreg_q;
    out_bit_d = out_bit_q;
    shift_cnt_d = shift_cnt_q;
    mode_sync_d = mode_sync_q;
    mode_link_d = mode_link_q;
    if (!cs_n) begin
      sreg_d = {sreg_q[`WORD_W-2:0], din};
      out_bit_d = sreg_q[`WORD_W-1];
      // The mode crosses only inside a frame, so dout holds while deselected.
      mode_sync_d = {mode_sync_q[`SYNC_STAGES-2:0], mode_q};
      if (mode_sync_q[1] == mode_sync_q[2]) begin
        mode_link_d = mode_sync_q[2];
      end
      if (shift_cnt_q != `SHIFT_CNT_MAX) begin
        shift_cnt_d = shift_cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge sclk or negedge resetn) begin
    if (!resetn) begin
      sreg_q <= `WORD_RST;
      out_bit_q <= `BIT_RST;
      shift_cnt_q <= `SHIFT_CNT_RST;
      mode_sync_q <= {`SYNC_STAGES{`MODE_FALL_EDGE}};
      mode_link_q <= `MODE_FALL_EDGE;
    end else begin
      sreg_q <= sreg_d;
      out_bit_q <= out_bit_d;
      shift_cnt_q <= shift_cnt_d;
      mode_sync_q <= mode_sync_d;
      mode_link_q <= mode_link_d;
    end
  end

  // A half-cycle retiming gives the extra half cycle of lag in falling mode.
  always_comb begin
    fall_d = cs_n ? fall_q : out_bit_q;
  end

  always_ff @(negedge sclk or negedge resetn) begin
    if (!resetn) begin
      fall_q <= `BIT_RST;
    end else begin
      fall_q <= fall_d;
    end
  end

  // The pin choice follows the mode seen by the link; a new mode settles
  // after four serial clock edges of the next frame.
  always_comb begin
    dout_d = mode_link_q ? out_bit_q : fall_q;
  end
  assign dout = dout_d;

  // ---------------- Command domain on the system clock ----------------
  logic cs_lvl;
  logic cs_prev_q, cs_prev_d;
  logic cs_rise;
  logic f_in_ready, f_out_valid, f_out_ready;
  word_t f_out_data;
  op_t op;
  code_t data;
  logic take;
  code_t [`NUM_CH-1:0] in_q, in_d, dac_q, dac_d;
  logic shdn_q, shdn_d, upo_q, upo_d, mode_d;
  logic word_ready_q, word_ready_d;

  level_sync #(.RESET_LEVEL(1'b1)) cs_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in(cs_n),
    .level(cs_lvl)
  );

  // The shift register is read across domains only after select has been
  // high for several clk cycles, while the serial clock stands still.
  assign cs_rise = cs_lvl && !cs_prev_q;

  word_fifo #(
    .WIDTH(`WORD_W),
    .DEPTH(DEPTH)
  ) cmd_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_valid(cs_rise),
    .in_ready(f_in_ready),
    .in_data(sreg_q),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  assign take = f_out_valid && !apply_hold;
  assign f_out_ready = take;
  assign op = f_out_data[`OP_MSB:`OP_LSB];
  assign data = f_out_data[`DATA_MSB:`DATA_LSB];

  always_comb begin
    cs_prev_d = cs_lvl;
    word_ready_d = f_in_ready;
    in_d = in_q;
    dac_d = dac_q;
    shdn_d = shdn_q;
    upo_d = upo_q;
    mode_d = mode_q;
    if (take) begin
      // A no-operation matches none of the branches below.
      if (is_load(op)) begin
        in_d[op[`SEL_MSB:`SEL_LSB]] = data;
      end
      for (int i = 0; i < `NUM_CH; i++) begin
        if (updates_all(op)) begin
          dac_d[i] = in_d[i];
        end else if (op == `OP_LOAD_ALL) begin
          dac_d[i] = data;
        end
      end
      if (op == `OP_UPDATE || op == `OP_LOAD_ALL) begin
        shdn_d = 1'b0;
      end
      if (op == `OP_SHUTDOWN) begin
        shdn_d = 1'b1;
      end
      if (op == `OP_UPO_LOW) begin
        upo_d = 1'b0;
      end
      if (op == `OP_UPO_HIGH) begin
        upo_d = 1'b1;
      end
      if (op == `OP_MODE_RISE) begin
        mode_d = 1'b1;
      end
      if (op == `OP_MODE_FALL) begin
        mode_d = `MODE_FALL_EDGE;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cs_prev_q <= 1'b1;
      word_ready_q <= 1'b0;
      in_q <= {`NUM_CH{`CODE_RST}};
      dac_q <= {`NUM_CH{`CODE_RST}};
      shdn_q <= `BIT_RST;
      upo_q <= `BIT_RST;
      mode_q <= `MODE_FALL_EDGE;
    end else begin
      cs_prev_q <= cs_prev_d;
      word_ready_q <= word_ready_d;
      in_q <= in_d;
      dac_q <= dac_d;
      shdn_q <= shdn_d;
      upo_q <= upo_d;
      mode_q <= mode_d;
    end
  end

  assign output_code_value = dac_q;
  assign shutdown = shdn_q;
  assign upo = upo_q;
  assign dout_rising_mode = mode_q;
  assign word_ready = word_ready_q;

  // ---------------- Assertions ----------------
  AST_SHIFT_IN: assert property (
    @(posedge sclk) disable iff (!resetn)
    !cs_n |=> sreg_q == {$past(sreg_q[`WORD_W-2:0]), $past(din)})
    else $error("shift register did not take din msb first");

  AST_LAG_RISE: assert property (
    @(posedge sclk) disable iff (!resetn)
    (!cs_n && shift_cnt_q >= `LAG_READY) |->
      out_bit_q == $past(din, `LAG_SAMPLED))
    else $error("rising mode output lag is not twelve cycles");

  AST_LAG_FALL: assert property (
    @(posedge sclk) disable iff (!resetn)
    (!cs_n && shift_cnt_q >= `LAG_READY) |-> fall_q == out_bit_q)
    else $error("falling mode output not half a cycle behind");

  AST_DOUT_HOLD: assert property (
    @(posedge clk) disable iff (!resetn)
    (cs_n && $past(cs_n)) |-> $stable(dout))
    else $error("chain output moved while deselected");

  AST_EXEC_ON_RISE: assert property (
    @(posedge clk) disable iff (!resetn)
    (cs_rise && !f_out_valid) ##2 !apply_hold |-> take)
    else $error("word not executed after select rose");

  AST_NOP_KEEPS: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && is_nop(op)) |=> $stable(in_q) && $stable(dac_q))
    else $error("no-operation changed a code register");

  AST_NOP_DECODE: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && is_nop(op)) |=>
      $stable(shdn_q) && $stable(upo_q) && $stable(mode_q))
    else $error("no-operation changed device state");

  AST_LOAD_ALL_CODE: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && op == `OP_LOAD_ALL) |=>
      dac_q[0] == $past(data) && dac_q[1] == $past(data) &&
      dac_q[2] == $past(data) && dac_q[3] == $past(data))
    else $error("load-all did not place the code on every channel");

  AST_MODE_SOURCE: assert property (
    @(posedge clk) disable iff (!resetn)
    $rose(mode_q) |-> $past(take && op == `OP_MODE_RISE))
    else $error("rising mode entered without its command");

  AST_MODE_FALL_SOURCE: assert property (
    @(posedge clk) disable iff (!resetn)
    $fell(mode_q) |-> $past(take && op == `OP_MODE_FALL))
    else $error("falling mode entered without its command");

  AST_CODES_ON_EXEC: assert property (
    @(posedge clk) disable iff (!resetn)
    !take |=> $stable(in_q) && $stable(dac_q))
    else $error("code register changed with no word executed");

  AST_UPDATE_COPY: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && op == `OP_UPDATE) |=> dac_q == $past(in_q))
    else $error("update did not copy input codes to the outputs");

  COV_NOP: cover property (@(posedge clk) disable iff (!resetn)
    take && is_nop(op));
  COV_LOAD_ALL: cover property (@(posedge clk) disable iff (!resetn)
    take && op == `OP_LOAD_ALL);
  COV_MODE_RISE: cover property (@(posedge clk) disable iff (!resetn)
    take && op == `OP_MODE_RISE);
  COV_FULL: cover property (@(posedge clk) disable iff (!resetn)
    !f_in_ready);
  COV_SHUTDOWN: cover property (@(posedge clk) disable iff (!resetn)
    take && op == `OP_SHUTDOWN);
endmodule : quad_dac_serial_chain_port

// ---- rtl/dac_map.svh ----
// Named constants of the quad converter serial port: word layout,
// command codes, reset values and link timing.
// Assumes it is included by bare name wherever a constant is needed.
`ifndef DAC_MAP_SVH
`define DAC_MAP_SVH

`define WORD_W 12
`define CODE_W 8
`define NUM_CH 4
`define SEL_W 2
`define FIFO_DEPTH 32
`define SYNC_STAGES 3
`define MODE_SYNC_W 2
`define SHIFT_CNT_W 4

// Field positions inside the 12-bit command word; select and control bits inside the 4-bit operation field.
`define OP_MSB 11
`define OP_LSB 8
`define DATA_MSB 7
`define DATA_LSB 0
`define SEL_MSB 3
`define SEL_LSB 2
`define CTL_MSB 1
`define CTL_LSB 0

// Four-bit operation codes, address bits above control bits.
`define OP_NOP 4'h0
`define OP_UPDATE 4'h4
`define OP_LOAD_ALL 4'h8
`define OP_SHUTDOWN 4'hC
`define OP_UPO_LOW 4'h2
`define OP_UPO_HIGH 4'h6
`define OP_MODE_RISE 4'hE
`define OP_MODE_FALL 4'hA
`define CTL_LOAD 2'h1
`define CTL_LOAD_UPD 2'h3

// Reset values.
`define CODE_RST 8'h00
`define WORD_RST 12'h000
`define BIT_RST 1'b0
`define MODE_FALL_EDGE 1'b0
`define SHIFT_CNT_RST 4'h0
`define SHIFT_CNT_MAX 4'hF

// Output lag in whole serial clock edges, as sampled at the rising edge.
`define LAG_SAMPLED 13
`define LAG_READY 4'hD

`endif

// ---- rtl/dac_pkg.sv ----
// Types shared by the quad converter serial port and its helpers.
// Assumes dac_map.svh is reachable on the include path.
`include "dac_map.svh"

package dac_pkg;
  typedef logic [`WORD_W-1:0] word_t;
  typedef logic [`CODE_W-1:0] code_t;
  typedef logic [`OP_MSB-`OP_LSB:0] op_t;
endpackage : dac_pkg

// ---- rtl/level_sync.sv ----
// Three-stage synchroniser with agreement filter for a slow level.
// Assumes the input changes far slower than the destination clock.
`timescale 1ns/1ps
`include "dac_map.svh"

module level_sync import dac_pkg::*; #(
  parameter logic RESET_LEVEL = 1'b1
) (
  // Destination clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Level in and filtered level out
  input wire logic async_in,
  output logic level
);
  logic [`SYNC_STAGES-1:0] stage_q;
  logic [`SYNC_STAGES-1:0] stage_d;
  logic level_q;
  logic level_d;

  // The first stage feeds only the second; the filter compares two and three.
  always_comb begin
    stage_d = {stage_q[`SYNC_STAGES-2:0], async_in};
    level_d = level_q;
    if (stage_q[1] == stage_q[2]) begin
      level_d = stage_q[2];
    end
  end

  // Reset loads every stage with the idle level, so no false edge follows.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage_q <= {`SYNC_STAGES{RESET_LEVEL}};
      level_q <= RESET_LEVEL;
    end else begin
      stage_q <= stage_d;
      level_q <= level_d;
    end
  end

  assign level = level_q;
endmodule : level_sync

// ---- rtl/word_fifo.sv ----
// Word FIFO with valid/ready on both sides and a registered output stage.
// Assumes one clock; the drain side may stall for any number of cycles.
`timescale 1ns/1ps

module word_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic ov_q, ov_d;
  logic [WIDTH-1:0] od_q, od_d;
  logic push, pop_mem;

  always_comb begin
    push = in_valid && in_ready;
    pop_mem = (cnt_q != '0) && (!ov_q || out_ready);
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop_mem ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q;
    if (push && !pop_mem) begin
      cnt_d = cnt_q + 1'b1;
    end else if (!push && pop_mem) begin
      cnt_d = cnt_q - 1'b1;
    end
    ov_d = ov_q;
    od_d = od_q;
    if (pop_mem) begin
      ov_d = 1'b1;
      od_d = mem[rd_q];
    end else if (out_ready) begin
      ov_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      ov_q <= 1'b0;
      od_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      ov_q <= ov_d;
      od_q <= od_d;
    end
  end

  // Storage has no reset, so it can map onto a RAM.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = ov_q;
  assign out_data = od_q;
endmodule : word_fifo

// ---- tb/host_model.sv ----
// Behavioural serial host master for the quad converter port.
// Assumes the bench calls send and reads seen after each frame.
`timescale 1ns/1ps

module host_model (
  // Serial link to the device
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout
);
  logic [63:0] seen;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
    seen = '0;
  end

  // Sends the n low bits of w MSB first with polarity and phase zero.
  // Sampling dout just before the fall tells the two output modes apart.
  task automatic send(input logic [63:0] w, input int n);
    int i;
    // Start just off the system clock edge so select never moves on it.
    #1;
    cs_n = 1'b0;
    for (i = n - 1; i >= 0; i--) begin
      din = w[i];
      #6;
      sclk = 1'b1;
      #5;
      seen = {seen[62:0], dout};
      #1;
      sclk = 1'b0;
    end
    #6;
    cs_n = 1'b1;
    din = ~w[0];
  endtask : send
endmodule : host_model

// ---- tb/testbench.sv ----
// Self-checking bench of the quad converter serial port.
// Assumes host_model drives the link at 12 ns per serial clock.
`timescale 1ns/1ps
`include "dac_map.svh"

module testbench import dac_pkg::*; ;
  logic clk, resetn, apply_hold, sclk, cs_n, din, dout;
  logic word_ready, shutdown, upo, dout_rising_mode;
  code_t [`NUM_CH-1:0] output_code_value;
  int error_cnt, check_count, cycles;

  quad_dac_serial_chain_port #(.DEPTH(`FIFO_DEPTH)) dut (
    .clk(clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .din(din),
    .dout(dout), .apply_hold(apply_hold), .word_ready(word_ready),
    .output_code_value(output_code_value), .shutdown(shutdown),
    .upo(upo), .dout_rising_mode(dout_rising_mode)
  );
  host_model host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

  always #25 clk = ~clk;

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  // The wait leaves room for the select synchroniser and execution.
  task automatic cmd(input word_t w);
    host.send({52'h0, w}, 12);
    repeat (12) @(posedge clk);
  endtask : cmd

  task automatic t_reset;
    check("codes", output_code_value, 32'h0);
    check("mode", dout_rising_mode, `MODE_FALL_EDGE);
    check("flags", {shutdown, upo, word_ready}, 3'b001);
    $display("test reset done");
  endtask : t_reset

  task automatic t_cmds;
    code_t vals[4] = '{8'hFF, 8'h80, 8'h01, 8'h00};
    for (int ch = 0; ch < 4; ch++) begin
      cmd({ch[1:0], `CTL_LOAD_UPD, vals[ch]});
      check("load upd", output_code_value[ch], vals[ch]);
    end
    cmd({2'h0, `CTL_LOAD, 8'h12});
    check("load only", output_code_value[0], 8'hFF);
    cmd({`OP_NOP, 8'hAB});
    check("nop", output_code_value, {8'h00, 8'h01, 8'h80, 8'hFF});
    cmd({`OP_UPDATE, 8'h00});
    check("update", output_code_value[0], 8'h12);
    cmd({`OP_LOAD_ALL, 8'h55});
    check("load all", output_code_value, 32'h55555555);
    cmd({`OP_SHUTDOWN, 8'h00});
    check("shutdown", shutdown, 1'b1);
    cmd({`OP_UPDATE, 8'h00});
    check("wake", shutdown, 1'b0);
    cmd({`OP_UPO_HIGH, 8'h00});
    check("upo high", upo, 1'b1);
    cmd({`OP_UPO_LOW, 8'h00});
    check("upo low", upo, 1'b0);
    $display("test commands done");
  endtask : t_cmds

  // A 24-bit frame through one device: first word comes out on dout.
  task automatic t_chain;
    word_t w1 = 12'hA5C;
    logic held;
    host.send({40'h0, w1, `OP_NOP, 8'hF0}, 24);
    check("chain m0", host.seen[10:0], w1[11:1]);
    held = dout;
    repeat (6) @(posedge clk);
    check("dout hold", dout, held);
    cmd({`OP_MODE_RISE, 8'h00});
    check("mode rise", dout_rising_mode, 1'b1);
    host.send({40'h0, w1, `OP_NOP, 8'hF0}, 24);
    check("chain m1", host.seen[11:0], w1);
    repeat (12) @(posedge clk);
    check("nop chain", output_code_value, 32'h00018012);
    cmd({`OP_MODE_FALL, 8'h00});
    check("mode fall", dout_rising_mode, 1'b0);
    $display("test chain done");
  endtask : t_chain

  // Fill the FIFO under hold until it refuses, then drain it.
  task automatic t_fifo;
    int n;
    n = 0;
    apply_hold <= 1'b1;
    while (word_ready === 1'b1 && n < 40) begin
      cmd({`OP_LOAD_ALL, n[7:0]});
      n++;
    end
    check("full", n >= `FIFO_DEPTH, 1'b1);
    check("refused", word_ready, 1'b0);
    cmd({`OP_LOAD_ALL, 8'hEE});
    check("stalled", output_code_value[0], 8'h12);
    apply_hold <= 1'b0;
    repeat (100) @(posedge clk);
    check("drained", output_code_value[0], n - 1);
    check("ready", word_ready, 1'b1);
    $display("test fifo done");
  endtask : t_fifo

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  // The whole run needs well under 3000 cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end

  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    apply_hold = 1'b0;
    error_cnt = 0;
    check_count = 0;
    cycles = 0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (8) @(posedge clk);
    t_reset();
    t_cmds();
    t_chain();
    t_fifo();
    print_verdict();
  end
endmodule : testbench
